// ===== core/bcf_pkg.sv
// package for the binary command frame interpreter: frame layout, status codes, states
// assumes one system clock; byte streams arrive one byte per strobe
package bcf_pkg;
  localparam int unsigned SER_FRAME_LEN = 9;
  localparam int unsigned CAN_FRAME_LEN = 7;
  localparam logic [3:0]  IDX_ADDR      = 4'h0;
  localparam logic [3:0]  IDX_CMD_SER   = 4'h1;
  localparam logic [3:0]  IDX_CMD_CAN   = 4'h0;
  localparam logic [3:0]  IDX_LAST_SER  = 4'h8;
  localparam logic [3:0]  IDX_LAST_CAN  = 4'h6;
  localparam logic [3:0]  IDX_CSUM_TX   = 4'h8;
  localparam logic [3:0]  IDX_STATUS_TX = 4'h2;
  localparam logic [3:0]  IDX_LAST_CAN_TX = 4'h7;
  localparam logic [3:0]  IDX_ZERO      = 4'h0;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

  localparam logic [7:0] ST_OK        = 8'h64;
  localparam logic [7:0] ST_STORED    = 8'h65;
  localparam logic [7:0] ST_BAD_CSUM  = 8'h01;
  localparam logic [7:0] ST_BAD_CMD   = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE  = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] ST_LOCKED    = 8'h05;
  localparam logic [7:0] ST_NOT_AVAIL = 8'h06;

  localparam logic [7:0] DEF_MOD_ADDR   = 8'h01;
  localparam logic [7:0] DEF_REPLY_ADDR = 8'h02;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } bcf_cmd_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  cmd;
    logic [31:0] value;
  } bcf_rsp_t;

  typedef enum logic [1:0] {
    S_RX   = 2'b00,
    S_EXEC = 2'b01,
    S_TX   = 2'b11,
    S_ERR  = 2'b10
  } bcf_state_t;
endpackage : bcf_pkg

// ===== core/bcf_csum.sv
// running 8-bit additive checksum
// assumes a clear together with an add restarts the sum at the new byte
module bcf_csum (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] din,
  output logic      [7:0] sum_q
);
  logic [7:0] sum_d;
  // a frame start may coincide with the first byte, which must still count
  assign sum_d = clr ? (add ? din : bcf_pkg::BYTE_ZERO) : (add ? sum_q + din : sum_q);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      sum_q <= bcf_pkg::BYTE_ZERO;
    else
      sum_q <= sum_d;
  end
endmodule // bcf_csum

// ===== core/bcf_interp.sv
// frame interpreter: gathers command bytes, hands the command out, sends one reply
// assumes an executor that answers exec_req with a single exec_done pulse,
// and a byte transmitter that raises tx_ready when it can take a byte

// Summary of operation
// - command payload is seven bytes: command, type, bank, four value bytes.
// - serial frames add a leading address and trailing checksum, nine bytes.
// - byte order is address, command, type, bank, value MSB first, checksum.
// - command checksum is the modulo-256 sum of all preceding bytes.
// - on CAN only the seven payload bytes travel; identifier is the address.
// - exactly one reply frame is sent for each accepted command frame.
// - reply order: reply address, module address, status, command, value, checksum.
// - reply checksum is the modulo-256 sum of the other reply bytes.
// - on CAN the reply omits address and checksum bytes.
// - successful execution reports status 100.
// - a command stored into program memory reports status 101.
// - error statuses 1 to 6 cover checksum, command, type, value, lock, availability.
// - processing completes before the reply is transmitted.
// - the bus is driven only while a reply is being sent.
// - nothing is transmitted except as a reply to a command.
// - commands either execute now or are stored for standalone running.
module bcf_interp (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              can_mode,
  input  wire logic [7:0]        mod_addr,
  input  wire logic [7:0]        reply_addr,
  input  wire logic              store_mode,
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_frame_start,
  input  wire logic              exec_done,
  input  wire bcf_pkg::bcf_rsp_t exec_rsp,
  input  wire logic              tx_ready,
  output bcf_pkg::bcf_cmd_t      cmd_q,
  output logic                   exec_req_q,
  output logic                   store_req_q,
  output logic                   tx_valid_q,
  output logic [7:0]             tx_data_q,
  output logic                   tx_last_q,
  output logic                   bus_drive_b_q,
  output logic                   busy_q
);
  bcf_pkg::bcf_state_t state_q;
  bcf_pkg::bcf_state_t state_d;
  logic [3:0]          idx_q;
  logic [3:0]          idx_d;
  logic [7:0]          rx_addr_q;
  bcf_pkg::bcf_rsp_t   rsp_q;
  logic [7:0]          rx_sum;
  logic [7:0]          tx_sum;
  logic [3:0]          last_rx_idx;
  logic [3:0]          first_tx_idx;
  logic [3:0]          cmd_base;
  logic [3:0]          pay_idx;
  logic [3:0]          rx_idx;
  logic [3:0]          last_tx_idx;
  logic [7:0]          reply_sum;
  logic                stored_q;
  logic                rx_take;
  logic                rx_last;
  logic                rx_is_csum;
  logic                csum_ok;
  logic                addr_ok;
  logic                tx_fire;
  logic                tx_end;
  logic                tx_load;
  logic [7:0]          tx_byte;
  logic                rx_clr;
  logic                tx_clr;

  assign rx_take      = (state_q == bcf_pkg::S_RX) && rx_valid;
  assign last_rx_idx  = can_mode ? bcf_pkg::IDX_LAST_CAN : bcf_pkg::IDX_LAST_SER;
  assign cmd_base     = can_mode ? bcf_pkg::IDX_CMD_CAN : bcf_pkg::IDX_CMD_SER;
  // a frame start restarts the byte count even in mid-frame
  assign rx_idx       = rx_frame_start ? bcf_pkg::IDX_ZERO : idx_q;
  assign pay_idx      = rx_idx - cmd_base;
  assign rx_last      = rx_take && (rx_idx == last_rx_idx);
  assign rx_is_csum   = !can_mode && (rx_idx == bcf_pkg::IDX_LAST_SER);
  assign csum_ok      = can_mode || (rx_sum == rx_data);
  assign addr_ok      = can_mode || (rx_addr_q == mod_addr);
  assign rx_clr       = rx_frame_start || (state_q != bcf_pkg::S_RX);
  // serial frames start at the reply address byte, CAN frames at the status byte
  assign first_tx_idx = can_mode ? bcf_pkg::IDX_STATUS_TX : bcf_pkg::IDX_ZERO;
  assign last_tx_idx  = can_mode ? bcf_pkg::IDX_LAST_CAN_TX : bcf_pkg::IDX_CSUM_TX;
  assign reply_sum    = reply_addr + mod_addr + rsp_q.status + rsp_q.cmd
                      + rsp_q.value[31:24] + rsp_q.value[23:16]
                      + rsp_q.value[15:8] + rsp_q.value[7:0];
  assign tx_fire      = tx_valid_q && tx_ready;
  assign tx_end       = tx_fire && tx_last_q;
  assign tx_load      = (state_q == bcf_pkg::S_TX) && (!tx_valid_q || tx_fire) && !tx_end;
  assign tx_clr       = (state_q != bcf_pkg::S_TX);

  bcf_csum u_rx_csum (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clr     (rx_clr),
    .add     (rx_take && !rx_is_csum),
    .din     (rx_data),
    .sum_q   (rx_sum)
  );

  bcf_csum u_tx_csum (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clr     (tx_clr),
    .add     (tx_load && (idx_q != bcf_pkg::IDX_CSUM_TX)),
    .din     (tx_byte),
    .sum_q   (tx_sum)
  );

  // reply byte selection in transmit order
  always_comb
  begin
    tx_byte = bcf_pkg::BYTE_ZERO;
    case (idx_q)
      4'h0:    tx_byte = reply_addr;
      4'h1:    tx_byte = mod_addr;
      4'h2:    tx_byte = rsp_q.status;
      4'h3:    tx_byte = rsp_q.cmd;
      4'h4:    tx_byte = rsp_q.value[31:24];
      4'h5:    tx_byte = rsp_q.value[23:16];
      4'h6:    tx_byte = rsp_q.value[15:8];
      4'h7:    tx_byte = rsp_q.value[7:0];
      4'h8:    tx_byte = tx_sum;
      default: tx_byte = bcf_pkg::BYTE_ZERO;
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    idx_d   = idx_q;
    case (state_q)
      bcf_pkg::S_RX:
      begin
        if (rx_frame_start && !rx_valid)
          idx_d = bcf_pkg::IDX_ZERO;
        else if (rx_last)
        begin
          idx_d = bcf_pkg::IDX_ZERO;
          if (!addr_ok)
            state_d = bcf_pkg::S_RX;
          else if (!csum_ok)
            state_d = bcf_pkg::S_ERR;
          else
            state_d = bcf_pkg::S_EXEC;
        end
        else if (rx_take)
          idx_d = rx_idx + 4'h1;
      end
      bcf_pkg::S_EXEC:
        if (exec_done)
        begin
          state_d = bcf_pkg::S_TX;
          idx_d   = first_tx_idx;
        end
      bcf_pkg::S_ERR:
      begin
        state_d = bcf_pkg::S_TX;
        idx_d   = first_tx_idx;
      end
      bcf_pkg::S_TX:
        if (tx_end)
        begin
          state_d = bcf_pkg::S_RX;
          idx_d   = bcf_pkg::IDX_ZERO;
        end
        else if (tx_load)
          idx_d = idx_q + 4'h1;
      default:
      begin
        state_d = bcf_pkg::S_RX;
        idx_d   = bcf_pkg::IDX_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_q <= bcf_pkg::S_RX;
      idx_q   <= bcf_pkg::IDX_ZERO;
    end
    else
    begin
      state_q <= state_d;
      idx_q   <= idx_d;
    end
  end

  // command field capture, value most significant byte first
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cmd_q     <= '0;
      rx_addr_q <= bcf_pkg::BYTE_ZERO;
    end
    else if (rx_take)
    begin
      if (!can_mode && rx_idx == bcf_pkg::IDX_ADDR)
        rx_addr_q <= rx_data;
      case (pay_idx)
        4'h0:    cmd_q.cmd           <= rx_data;
        4'h1:    cmd_q.typ           <= rx_data;
        4'h2:    cmd_q.bank          <= rx_data;
        4'h3:    cmd_q.value[31:24]  <= rx_data;
        4'h4:    cmd_q.value[23:16]  <= rx_data;
        4'h5:    cmd_q.value[15:8]   <= rx_data;
        4'h6:    cmd_q.value[7:0]    <= rx_data;
        default: cmd_q.bank          <= cmd_q.bank;
      endcase
    end
  end

  // one request pulse per good frame, routed to execution or storage
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      exec_req_q  <= 1'b0;
      store_req_q <= 1'b0;
      stored_q    <= 1'b0;
    end
    else
    begin
      exec_req_q  <= rx_last && addr_ok && csum_ok && !store_mode;
      store_req_q <= rx_last && addr_ok && csum_ok && store_mode;
      // the request is a pulse, so the store choice is kept for the reply
      if (rx_last)
        stored_q <= store_mode;
    end
  end

  // reply contents: executor answer, stored status, or checksum error
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      rsp_q <= '0;
    else if (state_q == bcf_pkg::S_EXEC && exec_done)
    begin
      rsp_q.cmd    <= cmd_q.cmd;
      rsp_q.value  <= exec_rsp.value;
      rsp_q.status <= stored_q ? bcf_pkg::ST_STORED : exec_rsp.status;
    end
    else if (state_q == bcf_pkg::S_ERR)
    begin
      rsp_q.cmd    <= cmd_q.cmd;
      rsp_q.value  <= '0;
      rsp_q.status <= bcf_pkg::ST_BAD_CSUM;
    end
  end

  // transmit stage, only ever loaded inside a reply
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      tx_valid_q <= 1'b0;
      tx_data_q  <= bcf_pkg::BYTE_ZERO;
      tx_last_q  <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_valid_q <= 1'b1;
      tx_data_q  <= tx_byte;
      tx_last_q  <= (idx_q == last_tx_idx);
    end
    else if (tx_fire)
    begin
      tx_valid_q <= 1'b0;
      tx_last_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      bus_drive_b_q <= 1'b1;
      busy_q        <= 1'b0;
    end
    else
    begin
      bus_drive_b_q <= !(state_d == bcf_pkg::S_TX);
      busy_q        <= (state_d != bcf_pkg::S_RX);
    end
  end

  sequence s_good_frame;
    rx_last && addr_ok && csum_ok;
  endsequence

  a_one_request: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_good_frame |=> (exec_req_q ^ store_req_q))
    else $error("good frame gave no single request");
  a_foreign_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rx_last && !addr_ok) |=> (state_q == bcf_pkg::S_RX) && !exec_req_q)
    else $error("foreign frame was answered");
  a_bad_csum: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (rx_last && addr_ok && !csum_ok) |=> ##1 (rsp_q.status == bcf_pkg::ST_BAD_CSUM))
    else $error("bad checksum not reported");
  a_tx_only_reply: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tx_valid_q |-> (state_q == bcf_pkg::S_TX))
    else $error("transmit outside a reply");
  a_drive_window: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !bus_drive_b_q |-> (state_q == bcf_pkg::S_TX))
    else $error("bus driven outside reply");
  a_exec_first: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_q == bcf_pkg::S_EXEC && !exec_done) |=> !tx_valid_q)
    else $error("reply before processing done");
  a_stored_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_q == bcf_pkg::S_EXEC && exec_done && stored_q)
      |=> (rsp_q.status == bcf_pkg::ST_STORED))
    else $error("stored command not status 101");
  a_reply_csum: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tx_load && idx_q == bcf_pkg::IDX_CSUM_TX) |=> (tx_data_q == $past(reply_sum)))
    else $error("reply checksum wrong");
  a_return_rx: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tx_end |=> (state_q == bcf_pkg::S_RX) && busy_q == 1'b0)
    else $error("no return to receive after reply");
endmodule // bcf_interp

// ===== test/bcf_host_model.sv
// host-side model: accepts reply bytes, promptly or with random stalls
// assumes the bench holds the next command back until reply_done pulses
module bcf_host_model (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic slow,
  input  wire logic stall_rnd,
  input  wire logic tx_valid_q,
  input  wire logic tx_last_q,
  output logic      tx_ready,
  output logic      reply_done
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    tx_ready   = 1'b0;
    reply_done = 1'b0;
  end

  always @(posedge clk_sys)
  begin
    tx_ready   <= rst_b & ~(slow & stall_rnd);
    reply_done <= rst_b & tx_valid_q & tx_ready & tx_last_q;
  end
endmodule // bcf_host_model

// ===== test/binary_command_frame_interpreter_tb.sv
// self-checking bench for the frame interpreter with a host model and an executor
// assumes the design sources under core/ and the host model are compiled first
module binary_command_frame_interpreter_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic               clk_sys = 1'b0;
  logic               rst_b, can_mode, store_mode, rx_valid, rx_frame_start, exec_done;
  logic               slow, stall_rnd, tx_ready, reply_done;
  logic [7:0]         mod_addr, reply_addr, rx_data, tx_data_q;
  bcf_pkg::bcf_rsp_t  exec_rsp, ex_rsp;
  bcf_pkg::bcf_cmd_t  cmd_q, exp_cmd, c;
  logic               exec_req_q, store_req_q, tx_valid_q, tx_last_q, bus_drive_b_q, busy_q;
  logic               exp_store;
  logic [31:0]        rng = 32'h8c49;
  logic [31:0]        w0, w1;
  logic [8:0]         e;
  logic [8:0]         exp_q[$];
  logic [7:0]         st_tab[7];
  int                 err_total = 0;
  int                 tests_run = 0;
  int                 n_req = 0;

  always #50 clk_sys = ~clk_sys;

  bcf_interp bcf_interp_inst (.clk_sys(clk_sys), .rst_b(rst_b), .can_mode(can_mode),
    .mod_addr(mod_addr), .reply_addr(reply_addr), .store_mode(store_mode),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_start(rx_frame_start),
    .exec_done(exec_done), .exec_rsp(exec_rsp), .tx_ready(tx_ready), .cmd_q(cmd_q),
    .exec_req_q(exec_req_q), .store_req_q(store_req_q), .tx_valid_q(tx_valid_q),
    .tx_data_q(tx_data_q), .tx_last_q(tx_last_q), .bus_drive_b_q(bus_drive_b_q),
    .busy_q(busy_q));

  bcf_host_model bcf_host_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow),
    .stall_rnd(stall_rnd), .tx_valid_q(tx_valid_q), .tx_last_q(tx_last_q),
    .tx_ready(tx_ready), .reply_done(reply_done));

  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // sends one frame, notes the expected reply bytes and waits for the reply
  task automatic send(input logic [7:0] adr, input logic [7:0] cerr, input logic [7:0] st,
                      input logic [31:0] rv, input logic ex);
    logic [7:0] f[9];
    logic [7:0] r[9];
    logic [7:0] fs;
    logic [7:0] rs;
    int         k;
    int         n0;
    n0 = n_req;
    exp_cmd = c;
    exp_store = store_mode;
    f = '{adr, c.cmd, c.typ, c.bank, c.value[31:24], c.value[23:16], c.value[15:8],
          c.value[7:0], 8'h00};
    r = '{reply_addr, mod_addr, st, c.cmd, rv[31:24], rv[23:16], rv[15:8], rv[7:0], 8'h00};
    fs = 8'h00;
    rs = 8'h00;
    for (k = 0; k < 8; k++)
    begin
      fs += f[k];
      rs += r[k];
    end
    f[8] = fs + cerr;
    r[8] = rs;
    if (adr === mod_addr || can_mode)
      for (k = can_mode ? 2 : 0; k <= (can_mode ? 7 : 8); k++)
        exp_q.push_back({k == (can_mode ? 7 : 8), r[k]});
    for (k = can_mode ? 1 : 0; k <= (can_mode ? 7 : 8); k++)
    begin
      @(posedge clk_sys);
      #1;
      rx_valid = 1'b1;
      rx_data = f[k];
      rx_frame_start = (k == (can_mode ? 1 : 0));
    end
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b0;
    rx_frame_start = 1'b0;
    rx_data = ~rx_data;
    if (adr === mod_addr || can_mode)
    begin
      for (k = 0; k < 300; k++)
      begin
        @(posedge clk_sys);
        #2;
        if (reply_done === 1'b1)
          break;
      end
      check("reply done", reply_done, 1'b1);
      check("busy after reply", busy_q, 1'b0);
    end
    else
    begin
      repeat (20) @(posedge clk_sys);
      check("busy after foreign frame", busy_q, 1'b0);
    end
    check("pending reply bytes", exp_q.size(), 0);
    check("request count", n_req, n0 + int'(ex));
  endtask

  // watches reply bytes and the bus enable
  always @(posedge clk_sys)
  begin
    if (tx_valid_q === 1'b1 && tx_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unsolicited byte", 1'b1, 1'b0);
      else
      begin
        e = exp_q.pop_front();
        check("reply byte", tx_data_q, e[7:0]);
        check("last flag", tx_last_q, e[8]);
        check("bus drive in reply", bus_drive_b_q, 1'b0);
      end
    end
    else if (rst_b === 1'b1 && busy_q === 1'b0)
      check("bus drive idle", bus_drive_b_q, 1'b1);
  end

  // executor: answers each request after a random pause
  always @(posedge clk_sys)
  begin
    if (exec_req_q === 1'b1 || store_req_q === 1'b1)
    begin
      n_req++;
      check("command out", cmd_q, exp_cmd);
      check("store request", store_req_q, exp_store);
      check("reply before done", tx_valid_q, 1'b0);
      check("busy in processing", busy_q, 1'b1);
      repeat (nxt() % 4) @(posedge clk_sys);
      #1;
      exec_done = 1'b1;
      exec_rsp = ex_rsp;
      @(posedge clk_sys);
      #1;
      exec_done = 1'b0;
      exec_rsp = 48'({nxt(), nxt()});
    end
  end

  always @(posedge clk_sys)
  begin
    #1;
    stall_rnd = nxt() > 32'h8000_0000;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    $display("watchdog expired");
    test_done();
  end

  initial
  begin
    {rst_b, can_mode, store_mode, rx_valid, rx_frame_start, exec_done, slow} = '0;
    stall_rnd = 1'b0;
    rx_data = 8'h00;
    exec_rsp = '0;
    ex_rsp = '0;
    mod_addr = bcf_pkg::DEF_MOD_ADDR;
    reply_addr = bcf_pkg::DEF_REPLY_ADDR;
    st_tab = '{bcf_pkg::ST_OK, bcf_pkg::ST_BAD_CMD, bcf_pkg::ST_BAD_TYPE,
               bcf_pkg::ST_BAD_VALUE, bcf_pkg::ST_LOCKED, bcf_pkg::ST_NOT_AVAIL,
               bcf_pkg::ST_OK};
    repeat (3) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      w0 = nxt();
      w1 = nxt();
      c = {w0[23:0], w1};
      ex_rsp = {st_tab[i % 7], w0[31:24], nxt()};
      slow = i[0];
      store_mode = (i == 7);
      can_mode = (i == 8);
      if (i == 9)
        send(mod_addr + 8'h01, 8'h00, 8'h00, 32'h0, 1'b0);
      else if (i == 6)
        send(mod_addr, 8'h01, bcf_pkg::ST_BAD_CSUM, 32'h0, 1'b0);
      else if (i == 7)
        send(mod_addr, 8'h00, bcf_pkg::ST_STORED, ex_rsp.value, 1'b1);
      else
        send(mod_addr, 8'h00, ex_rsp.status, ex_rsp.value, 1'b1);
      store_mode = 1'b0;
      can_mode = 1'b0;
    end
    test_done();
  end
endmodule // binary_command_frame_interpreter_tb
